// file: core/eeprom_ctrl_pkg.sv
package eeprom_ctrl_pkg;
    // Register offsets on the special function register port
    localparam logic [7:0] DATA_OFFSET    = 8'h9A;
    localparam logic [7:0] LOC_OFFSET     = 8'h9B;
    localparam logic [7:0] CTRL_OFFSET    = 8'h9C;
    localparam logic [7:0] UNLOCK_OFFSET  = 8'h9D;
    // Control register bit positions
    localparam int RD_BIT    = 0;
    localparam int WR_BIT    = 1;
    localparam int PERMIT_BIT = 2;
    localparam int ABORT_BIT  = 3;
    // Unlock sequence values
    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
    // Reset values
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // Storage geometry
    localparam int STORE_DEPTH = 128;
    localparam int LOC_BITS    = 7;
    // Default write time and power-up delay
    localparam int WRITE_TIME_NS   = 4000000;
    localparam int CLK_PERIOD_NS   = 100;
    localparam int WRITE_CYCLES    = WRITE_TIME_NS / CLK_PERIOD_NS;
    localparam int PWRUP_TIME_MS   = 72;
    localparam int PWRUP_CYCLES    = PWRUP_TIME_MS * 1000000 / CLK_PERIOD_NS;
    // Cycles allowed between unlock steps, as the processor issues them
    localparam int UNLOCK_GAP      = 2;
endpackage : eeprom_ctrl_pkg

// file: core/eeprom_cycle_timer.sv
`timescale 1ns/1ps
// Self-timed down counter for one erase/program cycle
module eeprom_cycle_timer #(
    parameter int CYCLES = 40000
) (
    input  wire logic core_clk,   // System clock
    input  wire logic reset,      // Synchronous reset
    input  wire logic start,      // Begin a timed interval
    output logic      busy,       // Interval running
    output logic      expire      // One-cycle pulse at end
);
    localparam int W = $clog2(CYCLES + 1);
    logic [W-1:0] count_q;
    logic [W-1:0] count_d;
    logic         expire_q;
    logic         expire_d;

    // Next count and expiry
    always_comb begin
        count_d  = count_q;
        expire_d = 1'b0;
        if (start) begin
            count_d = W'(CYCLES - 1);
        end else if (count_q != '0) begin
            count_d = count_q - W'(1);
            if (count_q == W'(1)) begin
                expire_d = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            count_q  <= '0;
            expire_q <= 1'b0;
        end else begin
            count_q  <= count_d;
            expire_q <= expire_d;
        end
    end

    assign busy   = (count_q != '0) || start;
    assign expire = expire_q;
endmodule : eeprom_cycle_timer

// file: core/eeprom_access_ctrl.sv
`timescale 1ns/1ps
// Operation
// - 128 bytes, locations 0 to 7F, bytewise
// - Each write erases then programs the byte
// - Internal timer sets write duration
// - Protection blocks programmer, not processor
// - Location top bit ignored in decode
// - Control upper nibble reads zero, ignores writes
// - Triggers set-only; hardware clears on completion
// - Writes need write permit set
// - Write permit zero at power-up
// - Abort flag set when pin, watchdog or brown-out reset cuts write
// - Aborting reset clears data and location
// - Done flag set on write; software clears
// - Unlock port stores nothing, reads zero
// - Read fills data register next cycle; ignored while a write runs
// - Data register holds until read or write
// - 8-bit data; registers reset to zero except the abort flag and the power-up delay
// - Write needs 55h, AAh, trigger in time
// - Permit clear keeps write; blocks trigger unless the trigger write sets it
// - Hardware never clears write permit
// - No writes during power-up delay
module eeprom_access_ctrl
    import eeprom_ctrl_pkg::*;
#(
    parameter int WRITE_CYC = WRITE_CYCLES,
    parameter int PWRUP_CYC = PWRUP_CYCLES
) (
    input  wire logic       core_clk,        // System clock, 10 MHz
    input  wire logic       reset,           // Synchronous device reset
    input  wire logic       power_on,        // Reset cause: power-on
    input  wire logic       external_reset_pin, // Reset cause: external pin
    input  wire logic       watchdog_timeout, // Reset cause: watchdog
    input  wire logic       brownout_detect, // Reset cause: brown-out
    input  wire logic [7:0] sfr_addr,        // Register address
    input  wire logic       sfr_wr,          // Register write strobe
    input  wire logic [7:0] sfr_wdata,       // Register write data
    output logic      [7:0] sfr_rdata,       // Register read data
    input  wire logic       data_protect,    // Data protection active
    input  wire logic       prog_rd,         // Programmer read request
    input  wire logic [6:0] prog_addr,       // Programmer location
    output logic      [7:0] prog_rdata,      // Programmer read data
    input  wire logic       flag_clear,      // Software clears done flag
    output logic            program_done_flag // Write-complete flag
);
    typedef enum logic [1:0] {IDLE, GOT_KEY1, GOT_KEY2} unlock_e;

    // Counter width for the power-up delay
    localparam int PW_W = $clog2(PWRUP_CYC + 1);

    // Byte array and the write it is waiting to commit
    logic [7:0]          store_q [STORE_DEPTH];  // Storage array
    logic [LOC_BITS-1:0] wloc_q;                 // Location taken at start
    logic [LOC_BITS-1:0] wloc_d;                 // Next write location
    logic [7:0]          wdat_q;                 // Byte taken at start
    logic [7:0]          wdat_d;                 // Next write byte
    logic                commit;                 // Array update this cycle

    // Software-visible registers
    logic [7:0]          data_q;                 // Data byte register
    logic [7:0]          data_d;                 // Next data byte
    logic [7:0]          loc_q;                  // Location register
    logic [7:0]          loc_d;                  // Next location
    logic                wr_q;                   // Store trigger
    logic                wr_d;                   // Next store trigger
    logic                permit_q;               // Write permit
    logic                permit_d;               // Next write permit
    logic                err_q;                  // Write abort flag
    logic                err_d;                  // Abort flag, run mode
    logic                err_n;                  // Abort flag, reset included
    logic                done_q;                 // Write-done flag
    logic                done_d;                 // Next write-done flag

    // Unlock sequencer, power-up delay and programmer port
    unlock_e             ul_q;                   // Unlock progress
    unlock_e             ul_d;                   // Next unlock progress
    logic [1:0]          gap_q;                  // Cycles left for next step
    logic [1:0]          gap_d;                  // Next step window
    logic [PW_W-1:0]     pw_q;                   // Power-up delay left
    logic [PW_W-1:0]     pw_d;                   // Delay, run mode
    logic [PW_W-1:0]     pw_n;                   // Delay, reset included
    logic [7:0]          prog_d;                 // Next programmer byte
    logic                start;                  // Write cycle begins
    logic                expire;                 // Write cycle ends
    logic                any_cut;                // Reset cause that cuts a write

    // Register write strobes
    logic                wr_data;                // Data byte written
    logic                wr_loc;                 // Location written
    logic                wr_ctrl;                // Control written
    logic                wr_unl;                 // Unlock port written

    // Address decode for writes; unmapped offsets fall through
    always_comb begin
        wr_data = 1'b0;
        wr_loc  = 1'b0;
        wr_ctrl = 1'b0;
        wr_unl  = 1'b0;
        if (sfr_addr == DATA_OFFSET) begin
            wr_data = sfr_wr;
        end else if (sfr_addr == LOC_OFFSET) begin
            wr_loc = sfr_wr;
        end else if (sfr_addr == CTRL_OFFSET) begin
            wr_ctrl = sfr_wr;
        end else if (sfr_addr == UNLOCK_OFFSET) begin
            wr_unl = sfr_wr;
        end
    end

    // Any of these during reset means a running write was cut
    assign any_cut = external_reset_pin || watchdog_timeout || brownout_detect;

    eeprom_cycle_timer #(
        .CYCLES (WRITE_CYC)
    ) u_timer (
        .core_clk (core_clk),
        .reset    (reset),
        .start    (start),
        .busy     (),
        .expire   (expire)
    );

    // Unlock sequencer; any other register write breaks the chain
    always_comb begin
        ul_d  = ul_q;
        gap_d = (gap_q != 2'd0) ? gap_q - 2'd1 : 2'd0;
        start = 1'b0;
        case (ul_q)
            IDLE: begin
                if (wr_unl && sfr_wdata == UNLOCK_KEY1) begin
                    ul_d  = GOT_KEY1;
                    gap_d = 2'(UNLOCK_GAP);
                end
            end
            GOT_KEY1: begin
                if (wr_unl && sfr_wdata == UNLOCK_KEY2) begin
                    ul_d  = GOT_KEY2;
                    gap_d = 2'(UNLOCK_GAP);
                end else if (sfr_wr || gap_q == 2'd0) begin
                    ul_d = IDLE;
                end
            end
            GOT_KEY2: begin
                if (wr_ctrl && sfr_wdata[WR_BIT]) begin
                    ul_d = IDLE;
                    // Permit must already be set or set by this write
                    start = !wr_q && (permit_q || sfr_wdata[PERMIT_BIT])
                            && pw_q == '0;
                end else if (sfr_wr || gap_q == 2'd0) begin
                    ul_d = IDLE;
                end
            end
            default: ul_d = IDLE;
        endcase
    end

    // Register next state
    always_comb begin
        data_d = data_q;
        loc_d  = loc_q;
        wr_d     = wr_q;
        permit_d = permit_q;
        err_d  = err_q;
        done_d = done_q;
        wloc_d = wloc_q;
        wdat_d = wdat_q;
        pw_d   = (pw_q != '0) ? pw_q - 1'b1 : pw_q;
        if (wr_data) begin
            data_d = sfr_wdata;
        end
        if (wr_loc) begin
            loc_d = sfr_wdata;
        end
        if (wr_ctrl) begin
            // Upper nibble dropped; trigger zeros ignored
            permit_d = sfr_wdata[PERMIT_BIT];
            err_d    = sfr_wdata[ABORT_BIT];
            // A read during a write is dropped; the array is busy
            if (sfr_wdata[RD_BIT] && !wr_q) begin
                data_d = store_q[loc_q[LOC_BITS-1:0]];
            end
        end
        if (start) begin
            wr_d   = 1'b1;
            wloc_d = loc_q[LOC_BITS-1:0];
            wdat_d = data_q;
        end else if (expire) begin
            wr_d   = 1'b0;
            err_d  = 1'b0;
            done_d = 1'b1;
        end
        // Completion beats a same-cycle software clear
        if (flag_clear && !expire) begin
            done_d = 1'b0;
        end
    end

    // The array changes only at expiry, so a cut write leaves the old byte
    assign commit = expire && !reset;

    // Byte array update; one location per completed write
    always_ff @(posedge core_clk) begin
        if (commit) begin
            store_q[wloc_q] <= wdat_q;
        end
    end

    // Abort flag ignores reset; a cut write sets it instead
    always_comb begin
        err_n = err_d;
        if (reset) begin
            err_n = err_q;
            if (wr_q && any_cut) begin
                err_n = 1'b1;
            end
        end
    end

    // Abort flag register, deliberately without a reset value
    always_ff @(posedge core_clk) begin
        err_q <= err_n;
    end

    // Software-visible registers and sequencer state
    // Abort flag and power-up delay live apart; they must survive reset
    always_ff @(posedge core_clk) begin
        if (reset) begin
            data_q   <= BYTE_RESET;
            loc_q    <= BYTE_RESET;
            wr_q     <= 1'b0;
            permit_q <= 1'b0;
            done_q   <= 1'b0;
            wloc_q   <= '0;
            wdat_q   <= BYTE_RESET;
            ul_q     <= IDLE;
            gap_q    <= 2'd0;
        end else begin
            data_q   <= data_d;
            loc_q    <= loc_d;
            wr_q     <= wr_d;
            permit_q <= permit_d;
            done_q   <= done_d;
            wloc_q   <= wloc_d;
            wdat_q   <= wdat_d;
            ul_q     <= ul_d;
            gap_q    <= gap_d;
        end
    end

    // Power-up delay reloads only on a power-on reset; other resets keep it
    always_comb begin
        pw_n = pw_d;
        if (reset) begin
            pw_n = pw_q;
            if (power_on) begin
                pw_n = PW_W'(PWRUP_CYC);
            end
        end
    end

    // Power-up delay register
    always_ff @(posedge core_clk) begin
        pw_q <= pw_n;
    end

    // Register readback; unlock port and unmapped offsets read zero
    // Combinational so a read needs no wait state
    always_comb begin
        sfr_rdata = 8'h00;
        if (sfr_addr == DATA_OFFSET) begin
            sfr_rdata = data_q;
        end else if (sfr_addr == LOC_OFFSET) begin
            sfr_rdata = loc_q;
        end else if (sfr_addr == CTRL_OFFSET) begin
            // Read trigger finishes on the edge that takes it, so it reads zero
            sfr_rdata = {4'h0, err_q, permit_q, wr_q, 1'b0};
        end
    end

    // Programmer fetch, blanked under protection; processor side unaffected
    always_comb begin
        prog_d = prog_rdata;
        if (prog_rd) begin
            prog_d = data_protect ? 8'h00 : store_q[prog_addr];
        end
    end

    // Programmer read data register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            prog_rdata <= 8'h00;
        end else begin
            prog_rdata <= prog_d;
        end
    end

    // Done flag stands until software clears it
    assign program_done_flag = done_q;
endmodule : eeprom_access_ctrl

// file: test/eeprom_access_chk.sv
`timescale 1ns/1ps
// Port-level checks on the register face
module eeprom_access_chk
    import eeprom_ctrl_pkg::*;
#(
    parameter int WRITE_CYC = WRITE_CYCLES,
    parameter int PWRUP_CYC = PWRUP_CYCLES
) (
    input wire logic       core_clk,          // Clock
    input wire logic       reset,             // Reset
    input wire logic [7:0] sfr_addr,          // Address
    input wire logic       sfr_wr,            // Write strobe
    input wire logic [7:0] sfr_wdata,         // Write data
    input wire logic [7:0] sfr_rdata,         // Read data
    input wire logic       data_protect,      // Protection
    input wire logic       prog_rd,           // Programmer read
    input wire logic [7:0] prog_rdata,        // Programmer data
    input wire logic       flag_clear,        // Flag clear
    input wire logic       program_done_flag  // Done flag
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // Readback is combinational, so each check keys on the selected register
    a_unlock_reads_zero: assert property (sfr_addr == UNLOCK_OFFSET |-> sfr_rdata == 8'h00)
        else $error("unlock port read nonzero");
    a_ctrl_upper_zero: assert property (sfr_addr == CTRL_OFFSET |-> sfr_rdata[7:4] == 4'h0)
        else $error("control upper bits nonzero");
    a_data_reset_zero: assert property ($past(reset) && sfr_addr == DATA_OFFSET |-> sfr_rdata == 8'h00)
        else $error("data not cleared by reset");
    a_permit_reset_zero: assert property ($past(reset) && sfr_addr == CTRL_OFFSET |-> sfr_rdata[2:0] == 3'h0)
        else $error("control bits not cleared by reset");
    a_read_self_clear: assert property (sfr_wr && sfr_addr == CTRL_OFFSET && sfr_wdata[RD_BIT] ##1
        sfr_addr == CTRL_OFFSET |-> !sfr_rdata[RD_BIT]) else $error("read trigger stuck");
    a_store_not_cleared: assert property (sfr_wr && sfr_addr == CTRL_OFFSET && sfr_rdata[WR_BIT] &&
        !sfr_wdata[WR_BIT] |=> sfr_rdata[WR_BIT] || program_done_flag) else $error("store trigger cleared");
    a_done_held: assert property (program_done_flag && !flag_clear |=> program_done_flag)
        else $error("done flag dropped");
    a_done_reset: assert property ($past(reset) |-> !program_done_flag)
        else $error("done flag survived reset");
    a_prog_protect: assert property (prog_rd && data_protect |=> prog_rdata == 8'h00)
        else $error("protected byte leaked");
    // Main scenarios
    c_done: cover property ($rose(program_done_flag));
    c_protect: cover property (prog_rd && data_protect);
    c_unlock: cover property (sfr_wr && sfr_addr == UNLOCK_OFFSET);
endmodule : eeprom_access_chk

bind eeprom_access_ctrl eeprom_access_chk #(.WRITE_CYC(WRITE_CYC), .PWRUP_CYC(PWRUP_CYC)) u_chk (
    .core_clk(core_clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .data_protect(data_protect), .prog_rd(prog_rd), .prog_rdata(prog_rdata),
    .flag_clear(flag_clear), .program_done_flag(program_done_flag));

// file: test/eeprom_programmer.sv
`timescale 1ns/1ps
// External programmer on the array's back door
module eeprom_programmer (
    input  wire logic       core_clk,   // Clock
    output logic            prog_rd,    // Read pulse
    output logic      [6:0] prog_addr,  // Location
    input  wire logic [7:0] prog_rdata  // Fetched byte
);
    // Idle until asked
    initial begin
        prog_rd = 1'b0;
        prog_addr = 7'h00;
    end
    // One-cycle fetch; address inverted after so stale values never look valid
    task automatic fetch(input logic [6:0] a, output logic [7:0] d);
        @(negedge core_clk);
        prog_addr = a;
        prog_rd = 1'b1;
        @(negedge core_clk);
        prog_rd = 1'b0;
        prog_addr = ~a;
        d = prog_rdata;
    endtask : fetch
endmodule : eeprom_programmer

// file: test/test_eeprom_access_ctrl.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; $display("BAD t=%0t %h/%h", $time, g, e); end end
module test_eeprom_access_ctrl;
    import eeprom_ctrl_pkg::*;
    localparam int WC = 5;
    logic       core_clk, reset, power_on, external_reset_pin, watchdog_timeout, brownout_detect;
    logic       sfr_wr, data_protect, prog_rd, flag_clear, program_done_flag;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, prog_rdata, d;
    logic [6:0] prog_addr;
    int         bad_count = 0;
    int         tests_run = 0;
    int         n;
    eeprom_access_ctrl #(.WRITE_CYC(WC), .PWRUP_CYC(10)) dut (
        .core_clk(core_clk), .reset(reset), .power_on(power_on), .external_reset_pin(external_reset_pin),
        .watchdog_timeout(watchdog_timeout), .brownout_detect(brownout_detect), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .data_protect(data_protect),
        .prog_rd(prog_rd), .prog_addr(prog_addr), .prog_rdata(prog_rdata), .flag_clear(flag_clear),
        .program_done_flag(program_done_flag));
    eeprom_programmer pgm (.core_clk(core_clk), .prog_rd(prog_rd), .prog_addr(prog_addr), .prog_rdata(prog_rdata));
    // 10 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // Strobe left high so back-to-back writes land one cycle apart
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge core_clk);
        sfr_addr = a;
        sfr_wdata = v;
        sfr_wr = 1'b1;
    endtask : wr
    task automatic tick(input int k);
        repeat (k) begin
            @(negedge core_clk);
            sfr_wr = 1'b0;
        end
    endtask : tick
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        tick(1);
        sfr_addr = a;
        #1 v = sfr_rdata;
    endtask : rd
    // Location top bit kept clear here
    task automatic store(input logic [7:0] loc, input logic [7:0] v);
        wr(LOC_OFFSET, loc);
        wr(DATA_OFFSET, v);
        wr(CTRL_OFFSET, 8'h04);
        wr(UNLOCK_OFFSET, UNLOCK_KEY1);
        wr(UNLOCK_OFFSET, UNLOCK_KEY2);
        wr(CTRL_OFFSET, 8'h06);
    endtask : store
    task automatic wait_wr(output int k);
        k = 0;
        rd(CTRL_OFFSET, d);
        while (d[WR_BIT] === 1'b1 && k < 40) begin
            k++;
            rd(CTRL_OFFSET, d);
        end
    endtask : wait_wr
    task automatic do_reset(input logic [3:0] c, input int k);
        tick(1);
        sfr_addr = c[3] ? DATA_OFFSET : CTRL_OFFSET;
        {power_on, external_reset_pin, watchdog_timeout, brownout_detect} = c;
        reset = 1'b1;
        repeat (k) @(negedge core_clk);
        reset = 1'b0;
        {power_on, external_reset_pin, watchdog_timeout, brownout_detect} = 4'h0;
    endtask : do_reset
    task automatic results;
        $display("mismatches %0d of %0d checks", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results
    // Hang guard, far beyond the expected few hundred cycles
    initial begin
        #(3000 * 100);
        bad_count++;
        results();
    end
    // Main sequence
    initial begin
        {sfr_wr, sfr_wdata, data_protect, flag_clear} = '0;
        {power_on, external_reset_pin, watchdog_timeout, brownout_detect} = 4'h8;
        sfr_addr = DATA_OFFSET;
        reset = 1'b1;
        do_reset(4'h8, 19);
        rd(UNLOCK_OFFSET, d);
        `CHK(d, 8'h00)
        store(8'h05, 8'h3C);
        tick(WC + 4);
        `CHK(program_done_flag, 1'b0)
        rd(CTRL_OFFSET, d);
        `CHK(d[2:1], 2'b10)
        store(8'h05, 8'h3C);
        rd(CTRL_OFFSET, d);
        `CHK(d[2:1], 2'b11)
        wr(CTRL_OFFSET, 8'h00);
        wait_wr(n);
        `CHK(n + 2, WC)
        `CHK(d[ABORT_BIT], 1'b0)
        tick(2);
        `CHK(program_done_flag, 1'b1)
        flag_clear = 1'b1;
        tick(1);
        flag_clear = 1'b0;
        `CHK(program_done_flag, 1'b0)
        wr(LOC_OFFSET, 8'h85);
        wr(CTRL_OFFSET, 8'h01);
        rd(CTRL_OFFSET, d);
        `CHK(d[RD_BIT], 1'b0)
        rd(DATA_OFFSET, d);
        `CHK(d, 8'h3C)
        wr(LOC_OFFSET, 8'h10);
        rd(DATA_OFFSET, d);
        `CHK(d, 8'h3C)
        pgm.fetch(7'h05, d);
        `CHK(d, 8'h3C)
        data_protect = 1'b1;
        pgm.fetch(7'h05, d);
        `CHK(d, 8'h00)
        data_protect = 1'b0;
        // Broken unlocks: no permit, swapped keys, late trigger
        wr(LOC_OFFSET, 8'h05);
        for (int i = 0; i < 3; i++) begin
            wr(DATA_OFFSET, 8'h77);
            wr(CTRL_OFFSET, i == 0 ? 8'h00 : 8'h04);
            wr(UNLOCK_OFFSET, i == 1 ? UNLOCK_KEY2 : UNLOCK_KEY1);
            wr(UNLOCK_OFFSET, i == 1 ? UNLOCK_KEY1 : UNLOCK_KEY2);
            if (i == 2) tick(3);
            wr(CTRL_OFFSET, i == 0 ? 8'h02 : 8'h06);
            tick(WC + 4);
            `CHK(program_done_flag, 1'b0)
        end
        wr(CTRL_OFFSET, 8'h01);
        rd(DATA_OFFSET, d);
        `CHK(d, 8'h3C)
        // Abort by each cutting reset cause: external pin, watchdog, brown-out
        for (int i = 0; i < 3; i++) begin
            store(8'h06, 8'hA5);
            tick(2);
            do_reset(4'h4 >> i, 2);
            rd(CTRL_OFFSET, d);
            `CHK(d[ABORT_BIT], 1'b1)
            rd(DATA_OFFSET, d);
            `CHK(d, 8'h00)
            rd(LOC_OFFSET, d);
            `CHK(d, 8'h00)
            do_reset(4'h0, 2);
            rd(CTRL_OFFSET, d);
            `CHK(d[ABORT_BIT], 1'b1)
            wr(CTRL_OFFSET, 8'h00);
            rd(CTRL_OFFSET, d);
            `CHK(d[ABORT_BIT], 1'b0)
        end
        store(8'h05, 8'hC3);
        wait_wr(n);
        wr(CTRL_OFFSET, 8'h01);
        rd(DATA_OFFSET, d);
        `CHK(d, 8'hC3)
        results();
    end
endmodule : test_eeprom_access_ctrl
